// ---- core/dmu_fifo.sv ----
// Frame-address FIFO with registered read data
`timescale 1ns/1ns
`default_nettype none
module dmu_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  input  wire logic         pop,
  output logic      [W-1:0] rdata,
  output logic              empty,
  output logic              full
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("dmu_fifo depth must be a power of two of at least 2");
    end
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [W-1:0]  rdata_q;
  logic          do_push;
  logic          do_pop;

  // Push into a full list is dropped; popping an empty list returns all ones
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign empty   = (cnt_q == '0);
  assign full    = (cnt_q == (AW+1)'(DEPTH));
  assign rdata   = rdata_q;

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wp_q] <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      rdata_q <= '1;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + AW'(1);
      end
      if (do_pop) begin
        rp_q    <= rp_q + AW'(1);
        rdata_q <= mem[rp_q];
      end else if (pop) begin
        rdata_q <= '1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule
`default_nettype wire

// ---- core/dmu_pkg.sv ----
// Constants shared by the doorbell and message unit
package dmu_pkg;
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 4;
  localparam int          QUEUE_DEPTH = 16;
  // Register word indices, same map on both ports except IDX_IN_STAT (core only) and IDX_OUT_STAT (host only)
  localparam logic [3:0]  IDX_IN_DB    = 4'h0;
  localparam logic [3:0]  IDX_OUT_DB   = 4'h1;
  localparam logic [3:0]  IDX_IN_MSG0  = 4'h2;
  localparam logic [3:0]  IDX_IN_MSG1  = 4'h3;
  localparam logic [3:0]  IDX_OUT_MSG0 = 4'h4;
  localparam logic [3:0]  IDX_OUT_MSG1 = 4'h5;
  localparam logic [3:0]  IDX_IN_QPORT = 4'h6;
  localparam logic [3:0]  IDX_OUT_QPORT = 4'h7;
  localparam logic [3:0]  IDX_IN_STAT  = 4'h8;
  localparam logic [3:0]  IDX_OUT_STAT = 4'h9;
  // Status field positions
  localparam int          STAT_MSG0_BIT = 0;
  localparam int          STAT_MSG1_BIT = 1;
  localparam int          STAT_POST_BIT = 2;
  // Reset values
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [31:0] EMPTY_QUEUE   = 32'hFFFF_FFFF;
  // Queue selectors
  localparam int          Q_IN_FREE  = 0;
  localparam int          Q_IN_POST  = 1;
  localparam int          Q_OUT_FREE = 2;
  localparam int          Q_OUT_POST = 3;
  localparam int          NUM_Q      = 4;
endpackage

// ---- core/dmu_skid.sv ----
// Two-entry read-data buffer toward the PCI side
`timescale 1ns/1ns
`default_nettype none
module dmu_skid #(
  parameter int W = 32
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready,
  output logic      [1:0]   count
);
  initial begin
    if (W < 1) begin
      $error("dmu_skid width must be positive");
    end
  end

  logic [W-1:0] head_q;
  logic [W-1:0] spare_q;
  logic         head_v_q;
  logic         spare_v_q;
  logic         acc;
  logic         pop;

  assign in_ready  = ~spare_v_q;
  assign out_valid = head_v_q;
  assign out_data  = head_q;
  assign count     = {head_v_q & spare_v_q, head_v_q ^ spare_v_q};
  assign acc       = in_valid & ~spare_v_q;
  assign pop       = head_v_q & out_ready;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      head_q    <= '0;
      spare_q   <= '0;
      head_v_q  <= 1'b0;
      spare_v_q <= 1'b0;
    end else begin
      // Head always holds the oldest word so a stall never reorders data
      if (~head_v_q || pop) begin
        if (spare_v_q) begin
          head_q    <= spare_q;
          head_v_q  <= 1'b1;
          spare_v_q <= acc;
          spare_q   <= in_data;
        end else begin
          head_q   <= in_data;
          head_v_q <= acc;
        end
      end else if (acc) begin
        spare_q   <= in_data;
        spare_v_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/dmu_top.sv ----
// Doorbell, message register and queue unit between core and PCI host
`timescale 1ns/1ns
`default_nettype none
module dmu_top #(
  parameter int QUEUE_DEPTH = dmu_pkg::QUEUE_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        pci_req,
  input  wire logic        pci_we,
  input  wire logic [3:0]  pci_addr,
  input  wire logic [31:0] pci_wdata,
  output logic             pci_ready,
  output logic      [31:0] pci_rdata,
  output logic             pci_rvalid,
  input  wire logic        pci_rready,
  input  wire logic        core_req,
  input  wire logic        core_we,
  input  wire logic [3:0]  core_addr,
  input  wire logic [31:0] core_wdata,
  output logic      [31:0] core_rdata,
  output logic             core_rvalid,
  output logic             core_irq,
  output logic             inta_n
);
  initial begin
    if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 4096) begin
      $error("dmu_top queue depth out of range");
    end
  end

  typedef struct packed {
    logic [31:0]      in_db;
    logic [31:0]      out_db;
    logic [1:0][31:0] in_msg;
    logic [1:0][31:0] out_msg;
    logic [1:0]       in_msg_pend;
    logic [1:0]       out_msg_pend;
    logic             p_rd;
    logic [3:0]       p_addr;
    logic             c_rd;
    logic [3:0]       c_addr;
    logic [31:0]      c_rdata;
    logic             c_rvalid;
    logic             pci_rdy;
    logic             core_irq;
    logic             inta_n;
  } dmu_state_t;

  dmu_state_t state_q;
  dmu_state_t state_d;

  logic              p_wr;
  logic              p_rd_new;
  logic              c_wr;
  logic              c_rd_new;
  logic [3:0]        q_push;
  logic [3:0]        q_pop;
  logic [3:0][31:0]  q_wdata;
  logic [3:0][31:0]  q_rdata;
  logic [3:0]        q_empty;
  logic [3:0]        q_full;
  logic [31:0]       p_rd_word;
  logic [1:0]        skid_cnt;
  logic              skid_in_ready;

  assign p_wr     = pci_req & pci_ready & pci_we;
  assign p_rd_new = pci_req & pci_ready & ~pci_we;
  assign c_wr     = core_req & core_we;
  assign c_rd_new = core_req & ~core_we;

  // Queue ports: host pops inbound free and pushes inbound post, the core the reverse
  always_comb begin
    q_push = '0;
    q_pop  = '0;
    q_wdata[dmu_pkg::Q_IN_FREE]  = core_wdata;
    q_wdata[dmu_pkg::Q_IN_POST]  = pci_wdata;
    q_wdata[dmu_pkg::Q_OUT_FREE] = pci_wdata;
    q_wdata[dmu_pkg::Q_OUT_POST] = core_wdata;
    if (pci_req && pci_ready && pci_addr == dmu_pkg::IDX_IN_QPORT) begin
      q_push[dmu_pkg::Q_IN_POST] = pci_we;
      q_pop[dmu_pkg::Q_IN_FREE]  = ~pci_we;
    end
    if (pci_req && pci_ready && pci_addr == dmu_pkg::IDX_OUT_QPORT) begin
      q_push[dmu_pkg::Q_OUT_FREE] = pci_we;
      q_pop[dmu_pkg::Q_OUT_POST]  = ~pci_we;
    end
    if (core_req && core_addr == dmu_pkg::IDX_IN_QPORT) begin
      q_push[dmu_pkg::Q_IN_FREE] = core_we;
      q_pop[dmu_pkg::Q_IN_POST]  = ~core_we;
    end
    if (core_req && core_addr == dmu_pkg::IDX_OUT_QPORT) begin
      q_push[dmu_pkg::Q_OUT_POST] = core_we;
      q_pop[dmu_pkg::Q_OUT_FREE]  = ~core_we;
    end
  end

  // Each direction has a free list and a post list, one FIFO per list
  for (genvar g = 0; g < dmu_pkg::NUM_Q; g++) begin : g_queue
    dmu_fifo #(
      .W     (dmu_pkg::DATA_W),
      .DEPTH (QUEUE_DEPTH)
    ) u_fifo (
      .clock   (clock),
      .sys_rst (sys_rst),
      .push    (q_push[g]),
      .wdata   (q_wdata[g]),
      .pop     (q_pop[g]),
      .rdata   (q_rdata[g]),
      .empty   (q_empty[g]),
      .full    (q_full[g])
    );
  end

  // Read word for the host, taken one cycle after the request
  always_comb begin
    case (state_q.p_addr)
      dmu_pkg::IDX_IN_DB:     p_rd_word = state_q.in_db;
      dmu_pkg::IDX_OUT_DB:    p_rd_word = state_q.out_db;
      dmu_pkg::IDX_IN_MSG0:   p_rd_word = state_q.in_msg[0];
      dmu_pkg::IDX_IN_MSG1:   p_rd_word = state_q.in_msg[1];
      dmu_pkg::IDX_OUT_MSG0:  p_rd_word = state_q.out_msg[0];
      dmu_pkg::IDX_OUT_MSG1:  p_rd_word = state_q.out_msg[1];
      dmu_pkg::IDX_IN_QPORT:  p_rd_word = q_rdata[dmu_pkg::Q_IN_FREE];
      dmu_pkg::IDX_OUT_QPORT: p_rd_word = q_rdata[dmu_pkg::Q_OUT_POST];
      dmu_pkg::IDX_OUT_STAT:  p_rd_word = {29'h0, ~q_empty[dmu_pkg::Q_OUT_POST],
                                           state_q.out_msg_pend};
      default:                p_rd_word = dmu_pkg::RST_WORD;
    endcase
  end

  dmu_skid #(
    .W (dmu_pkg::DATA_W)
  ) u_skid (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (state_q.p_rd),
    .in_data   (p_rd_word),
    .in_ready  (skid_in_ready),
    .out_valid (pci_rvalid),
    .out_data  (pci_rdata),
    .out_ready (pci_rready),
    .count     (skid_cnt)
  );

  always_comb begin
    state_d = state_q;
    // Doorbells: set wins over a clear arriving in the same cycle
    state_d.in_db = state_q.in_db;
    if (c_wr && core_addr == dmu_pkg::IDX_IN_DB) begin
      state_d.in_db = state_q.in_db & ~core_wdata;
    end
    if (p_wr && pci_addr == dmu_pkg::IDX_IN_DB) begin
      state_d.in_db = state_d.in_db | pci_wdata;
    end
    if (p_wr && pci_addr == dmu_pkg::IDX_OUT_DB) begin
      state_d.out_db = state_q.out_db & ~pci_wdata;
    end
    if (c_wr && core_addr == dmu_pkg::IDX_OUT_DB) begin
      state_d.out_db = state_d.out_db | core_wdata;
    end
    // Message pending flags clear by writing ones to the status word
    if (c_wr && core_addr == dmu_pkg::IDX_IN_STAT) begin
      state_d.in_msg_pend = state_q.in_msg_pend & ~core_wdata[1:0];
    end
    if (p_wr && pci_addr == dmu_pkg::IDX_OUT_STAT) begin
      state_d.out_msg_pend = state_q.out_msg_pend & ~pci_wdata[1:0];
    end
    if (p_wr && pci_addr == dmu_pkg::IDX_IN_MSG0) begin
      state_d.in_msg[0]                          = pci_wdata;
      state_d.in_msg_pend[dmu_pkg::STAT_MSG0_BIT] = 1'b1;
    end
    if (p_wr && pci_addr == dmu_pkg::IDX_IN_MSG1) begin
      state_d.in_msg[1]                          = pci_wdata;
      state_d.in_msg_pend[dmu_pkg::STAT_MSG1_BIT] = 1'b1;
    end
    if (c_wr && core_addr == dmu_pkg::IDX_OUT_MSG0) begin
      state_d.out_msg[0]                          = core_wdata;
      state_d.out_msg_pend[dmu_pkg::STAT_MSG0_BIT] = 1'b1;
    end
    if (c_wr && core_addr == dmu_pkg::IDX_OUT_MSG1) begin
      state_d.out_msg[1]                          = core_wdata;
      state_d.out_msg_pend[dmu_pkg::STAT_MSG1_BIT] = 1'b1;
    end
    // Reads: host through the buffer, core through a register
    state_d.p_rd   = p_rd_new;
    state_d.p_addr = pci_addr;
    state_d.c_rd   = c_rd_new;
    state_d.c_addr = core_addr;
    state_d.c_rvalid = state_q.c_rd;
    case (state_q.c_addr)
      dmu_pkg::IDX_IN_DB:     state_d.c_rdata = state_q.in_db;
      dmu_pkg::IDX_OUT_DB:    state_d.c_rdata = state_q.out_db;
      dmu_pkg::IDX_IN_MSG0:   state_d.c_rdata = state_q.in_msg[0];
      dmu_pkg::IDX_IN_MSG1:   state_d.c_rdata = state_q.in_msg[1];
      dmu_pkg::IDX_OUT_MSG0:  state_d.c_rdata = state_q.out_msg[0];
      dmu_pkg::IDX_OUT_MSG1:  state_d.c_rdata = state_q.out_msg[1];
      dmu_pkg::IDX_IN_QPORT:  state_d.c_rdata = q_rdata[dmu_pkg::Q_IN_POST];
      dmu_pkg::IDX_OUT_QPORT: state_d.c_rdata = q_rdata[dmu_pkg::Q_OUT_FREE];
      dmu_pkg::IDX_IN_STAT:   state_d.c_rdata = {29'h0, ~q_empty[dmu_pkg::Q_IN_POST],
                                                 state_q.in_msg_pend};
      default:                state_d.c_rdata = dmu_pkg::RST_WORD;
    endcase
    if (!state_q.c_rd) begin
      state_d.c_rdata = state_q.c_rdata;
    end
    // Conservative: counts words in flight so a stalled host never overflows the buffer
    state_d.pci_rdy = ({1'b0, skid_cnt} + {2'b00, state_q.p_rd} + {2'b00, p_rd_new})
                      <= 3'd1;
    // Host-bound events drive the PCI line, core-bound events the internal request
    state_d.core_irq = (|state_q.in_db) | (|state_q.in_msg_pend)
                       | ~q_empty[dmu_pkg::Q_IN_POST];
    state_d.inta_n = ~((|state_q.out_db) | (|state_q.out_msg_pend)
                       | ~q_empty[dmu_pkg::Q_OUT_POST]);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q         <= '0;
      state_q.pci_rdy <= 1'b1;
      state_q.inta_n  <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign pci_ready   = state_q.pci_rdy;
  assign core_rdata  = state_q.c_rdata;
  assign core_rvalid = state_q.c_rvalid;
  assign core_irq    = state_q.core_irq;
  assign inta_n      = state_q.inta_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence host_in_msg0_s;
    p_wr && pci_addr == dmu_pkg::IDX_IN_MSG0;
  endsequence

  sequence msg0_pending_s;
    state_q.in_msg_pend[0] ##1 core_irq;
  endsequence

  in_db_set_a: assert property (p_wr && pci_addr == dmu_pkg::IDX_IN_DB
    |=> (state_q.in_db & $past(pci_wdata)) == $past(pci_wdata))
    else $error("inbound doorbell bit not recorded");
  in_db_keep_a: assert property (!(c_wr && core_addr == dmu_pkg::IDX_IN_DB)
    |=> (state_q.in_db & $past(state_q.in_db)) == $past(state_q.in_db))
    else $error("inbound doorbell cleared without core write");
  core_irq_db_a: assert property ((|state_q.in_db) |=> core_irq)
    else $error("core interrupt missing for doorbell");
  out_db_inta_a: assert property (c_wr && core_addr == dmu_pkg::IDX_OUT_DB
    && core_wdata != '0 |=> ##1 !inta_n)
    else $error("INTA not asserted after outbound doorbell");
  out_db_clear_a: assert property (p_wr && pci_addr == dmu_pkg::IDX_OUT_DB
    && !c_wr |=> state_q.out_db == ($past(state_q.out_db) & ~$past(pci_wdata)))
    else $error("outbound doorbell clear wrong");
  in_msg_irq_a: assert property (host_in_msg0_s |=> msg0_pending_s)
    else $error("inbound message did not interrupt core");
  out_msg_inta_a: assert property (c_wr && core_addr == dmu_pkg::IDX_OUT_MSG1
    |=> state_q.out_msg_pend[1] ##1 !inta_n)
    else $error("outbound message did not assert INTA");
  out_post_inta_a: assert property (q_push[dmu_pkg::Q_OUT_POST]
    && !q_full[dmu_pkg::Q_OUT_POST] |=> ##1 !inta_n)
    else $error("posted outbound frame did not assert INTA");
  inta_release_a: assert property (state_q.out_db == '0 && state_q.out_msg_pend == '0
    && q_empty[dmu_pkg::Q_OUT_POST] |=> inta_n)
    else $error("INTA held with nothing pending");
  core_irq_hold_a: assert property (state_q.in_msg_pend != '0 |=> core_irq)
    else $error("core interrupt dropped while message pending");
  buffer_room_a: assert property (state_q.p_rd |-> skid_in_ready)
    else $error("read data arrived with buffer full");

  sequence host_rd_taken_s;
    p_rd_new;
  endsequence

  sequence word_buffered_s;
    state_q.p_rd ##1 pci_rvalid;
  endsequence

  // Pins lag the state by one edge, so the checks from an access to a pin or to pci_rvalid look one cycle further
  host_rd_path_a: assert property (host_rd_taken_s |=> word_buffered_s)
    else $error("host read word not buffered");
  rdy_refuse_a: assert property (skid_cnt == 2'd2 |=> !pci_ready)
    else $error("host request allowed with buffer full");
  core_rd_pulse_a: assert property (c_rd_new |=> ##1 core_rvalid)
    else $error("core read answer missing");
  out_db_set_a: assert property (c_wr && core_addr == dmu_pkg::IDX_OUT_DB
    |=> (state_q.out_db & $past(core_wdata)) == $past(core_wdata))
    else $error("outbound doorbell bit not recorded");
  out_db_keep_a: assert property (!(p_wr && pci_addr == dmu_pkg::IDX_OUT_DB)
    |=> (state_q.out_db & $past(state_q.out_db)) == $past(state_q.out_db))
    else $error("outbound doorbell cleared without host write");
  in_db_clear_a: assert property (c_wr && core_addr == dmu_pkg::IDX_IN_DB && !p_wr
    |=> state_q.in_db == ($past(state_q.in_db) & ~$past(core_wdata)))
    else $error("inbound doorbell clear wrong");
  in_db_irq_a: assert property (p_wr && pci_addr == dmu_pkg::IDX_IN_DB
    && pci_wdata != '0 |=> ##1 core_irq)
    else $error("core interrupt missing after doorbell write");
  in_msg_store_a: assert property (p_wr && pci_addr == dmu_pkg::IDX_IN_MSG1
    |=> state_q.in_msg[1] == $past(pci_wdata))
    else $error("inbound message not stored");
  in_msg1_irq_a: assert property (p_wr && pci_addr == dmu_pkg::IDX_IN_MSG1
    |=> ##1 core_irq)
    else $error("second inbound message did not interrupt core");
  out_msg_store_a: assert property (c_wr && core_addr == dmu_pkg::IDX_OUT_MSG0
    |=> state_q.out_msg[0] == $past(core_wdata))
    else $error("outbound message not stored");
  out_msg0_inta_a: assert property (c_wr && core_addr == dmu_pkg::IDX_OUT_MSG0
    |=> ##1 !inta_n)
    else $error("first outbound message did not assert INTA");
  out_db_hold_a: assert property (state_q.out_db != '0 |=> !inta_n)
    else $error("INTA dropped while doorbell set");
  out_post_hold_a: assert property (!q_empty[dmu_pkg::Q_OUT_POST] |=> !inta_n)
    else $error("INTA dropped while frame posted");
  in_post_irq_a: assert property (!q_empty[dmu_pkg::Q_IN_POST] |=> core_irq)
    else $error("posted inbound frame did not interrupt core");
  core_irq_release_a: assert property (state_q.in_db == '0
    && state_q.in_msg_pend == '0 && q_empty[dmu_pkg::Q_IN_POST] |=> !core_irq)
    else $error("core interrupt held with nothing pending");
  free_full_a: assert property (q_full[dmu_pkg::Q_IN_FREE]
    && !q_pop[dmu_pkg::Q_IN_FREE] |=> q_full[dmu_pkg::Q_IN_FREE])
    else $error("full free list lost its frames");
  empty_pop_a: assert property (q_empty[dmu_pkg::Q_IN_FREE]
    && q_pop[dmu_pkg::Q_IN_FREE] |=> q_rdata[dmu_pkg::Q_IN_FREE] == dmu_pkg::EMPTY_QUEUE)
    else $error("empty free list pop did not return all ones");
endmodule
`default_nettype wire

// ---- verif/dmu_host_model.sv ----
// Behavioural PCI host model driving the host port of the unit
`timescale 1ns/1ns
`default_nettype none
module dmu_host_model (
  input  wire logic        clock,
  input  wire logic        pci_ready,
  input  wire logic [31:0] pci_rdata,
  input  wire logic        pci_rvalid,
  output var  logic        pci_req,
  output var  logic        pci_we,
  output var  logic [3:0]  pci_addr,
  output var  logic [31:0] pci_wdata,
  output var  logic        pci_rready
);
  initial begin
    pci_req    = 1'h0;
    pci_we     = 1'h0;
    pci_addr   = 4'h0;
    pci_wdata  = 32'h0000_0000;
    pci_rready = 1'h0;
  end
  // Host reaches words only through the mapped port; writes set or clear doorbell bits, store messages or push frames
  task automatic issue(input logic we, input logic [3:0] addr, input logic [31:0] data,
                       output logic ok);
    int n;
    ok = 1'h0;
    @(negedge clock);
    pci_req   = 1'h1;
    pci_we    = we;
    pci_addr  = addr;
    pci_wdata = data;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clock);
      ok = (pci_ready === 1'h1);
    end
    @(negedge clock);
    pci_req   = 1'h0;
    // Released lines flip so a stale value is never mistaken for a live one
    pci_addr  = ~pci_addr;
    pci_wdata = ~pci_wdata;
  endtask
  // Read words are held low on pci_rready until this task is called: a stall
  task automatic collect(output logic [31:0] data, output logic ok);
    int n;
    ok   = 1'h0;
    data = 32'h0000_0000;
    @(negedge clock);
    pci_rready = 1'h1;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clock);
      if (pci_rvalid === 1'h1) begin
        ok   = 1'h1;
        data = pci_rdata;
      end
    end
    @(negedge clock);
    pci_rready = 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench for the doorbell and message unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int QD = 4;
  logic        clock;
  logic        sys_rst;
  logic        core_req;
  logic        core_we;
  logic [3:0]  core_addr;
  logic [31:0] core_wdata;
  logic [31:0] core_rdata;
  logic        core_rvalid;
  logic        core_irq;
  logic        inta_n;
  logic        pci_req;
  logic        pci_we;
  logic [3:0]  pci_addr;
  logic [31:0] pci_wdata;
  logic        pci_ready;
  logic [31:0] pci_rdata;
  logic        pci_rvalid;
  logic        pci_rready;
  int          fail_count = 0;
  int          compares = 0;
  logic        ok;
  logic [3:0]  k;
  logic [31:0] d;
  logic [31:0] msg;

  // Small queue depth so the full case is cheap to reach
  dmu_top #(.QUEUE_DEPTH(QD)) dmu_top_inst (
    .clock(clock), .sys_rst(sys_rst), .pci_req(pci_req), .pci_we(pci_we),
    .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_ready(pci_ready),
    .pci_rdata(pci_rdata), .pci_rvalid(pci_rvalid), .pci_rready(pci_rready),
    .core_req(core_req), .core_we(core_we), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .core_irq(core_irq), .inta_n(inta_n));
  dmu_host_model dmu_host_model_inst (
    .clock(clock), .pci_ready(pci_ready), .pci_rdata(pci_rdata),
    .pci_rvalid(pci_rvalid), .pci_req(pci_req), .pci_we(pci_we),
    .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_rready(pci_rready));

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input logic done);
    if (done !== 1'h1) begin
      fail_count++;
      $display("Error at %0t: handshake timed out", $time);
      finish_test();
    end
  endtask
  // Interrupt pins follow the state two edges after the access
  task automatic pins(input logic irq, input logic inta);
    repeat (2) @(negedge clock);
    check({31'h0, core_irq}, {31'h0, irq});
    check({31'h0, inta_n}, {31'h0, inta});
  endtask
  task automatic core_wr(input logic [3:0] addr, input logic [31:0] data);
    @(negedge clock);
    core_req   = 1'h1;
    core_we    = 1'h1;
    core_addr  = addr;
    core_wdata = data;
    @(negedge clock);
    core_req   = 1'h0;
    core_wdata = ~data;
  endtask
  task automatic core_rd(input logic [3:0] addr, input logic [31:0] exp);
    int   n;
    logic got;
    got = 1'h0;
    @(negedge clock);
    core_req  = 1'h1;
    core_we   = 1'h0;
    core_addr = addr;
    @(negedge clock);
    core_req  = 1'h0;
    for (n = 0; n < 8 && !got; n++) begin
      @(posedge clock);
      #1;
      got = (core_rvalid === 1'h1);
    end
    guard(got);
    check(core_rdata, exp);
  endtask
  task automatic host_wr(input logic [3:0] addr, input logic [31:0] data);
    logic got;
    dmu_host_model_inst.issue(1'h1, addr, data, got);
    guard(got);
  endtask
  task automatic host_rd(input logic [3:0] addr, input logic [31:0] exp);
    logic        got;
    logic [31:0] v;
    dmu_host_model_inst.issue(1'h0, addr, 32'h0000_0000, got);
    guard(got);
    dmu_host_model_inst.collect(v, got);
    guard(got);
    check(v, exp);
  endtask

  initial begin
    sys_rst    = 1'h1;
    core_req   = 1'h0;
    core_we    = 1'h0;
    core_addr  = 4'h0;
    core_wdata = 32'h0000_0000;
    repeat (5) @(negedge clock);
    sys_rst = 1'h0;
    check({31'h0, pci_ready}, 32'h0000_0001);
    pins(1'h0, 1'h1);
    for (k = 4'h0; k < 4'h6; k++) begin
      core_rd(k, dmu_pkg::RST_WORD);
    end
    // Inbound doorbell: host ORs bits in, only the core clears them
    host_wr(dmu_pkg::IDX_IN_DB, 32'h8000_0001);
    pins(1'h1, 1'h1);
    host_wr(dmu_pkg::IDX_IN_DB, 32'h0000_0002);
    core_rd(dmu_pkg::IDX_IN_DB, 32'h8000_0003);
    core_wr(dmu_pkg::IDX_IN_DB, 32'h8000_0001);
    pins(1'h1, 1'h1);
    core_rd(dmu_pkg::IDX_IN_DB, 32'h0000_0002);
    core_wr(dmu_pkg::IDX_IN_DB, 32'h0000_0002);
    pins(1'h0, 1'h1);
    // Outbound doorbell: core sets, only the host clears
    core_wr(dmu_pkg::IDX_OUT_DB, 32'h0000_00F0);
    pins(1'h0, 1'h0);
    core_wr(dmu_pkg::IDX_OUT_DB, 32'h0000_000F);
    host_rd(dmu_pkg::IDX_OUT_DB, 32'h0000_00FF);
    host_wr(dmu_pkg::IDX_OUT_DB, 32'h0000_000F);
    host_rd(dmu_pkg::IDX_OUT_DB, 32'h0000_00F0);
    pins(1'h0, 1'h0);
    host_wr(dmu_pkg::IDX_OUT_DB, 32'h0000_00F0);
    pins(1'h0, 1'h1);
    // Both message registers in each direction
    for (k = 4'h0; k < 4'h2; k++) begin
      msg = 32'hC0DE_0000 | {28'h0000_000, k};
      host_wr(dmu_pkg::IDX_IN_MSG0 + k, msg);
      pins(1'h1, 1'h1);
      core_rd(dmu_pkg::IDX_IN_MSG0 + k, msg);
      core_rd(dmu_pkg::IDX_IN_STAT, 32'h0000_0001 << k);
      core_wr(dmu_pkg::IDX_IN_STAT, 32'h0000_0001 << k);
      pins(1'h0, 1'h1);
      core_wr(dmu_pkg::IDX_OUT_MSG0 + k, ~msg);
      pins(1'h0, 1'h0);
      host_rd(dmu_pkg::IDX_OUT_MSG0 + k, ~msg);
      host_rd(dmu_pkg::IDX_OUT_STAT, 32'h0000_0001 << k);
      host_wr(dmu_pkg::IDX_OUT_STAT, 32'h0000_0001 << k);
      pins(1'h0, 1'h1);
    end
    // Inbound free list filled past full, then drained past empty
    for (k = 4'h0; k < 4'h5; k++) begin
      core_wr(dmu_pkg::IDX_IN_QPORT, 32'h0000_0100 + {28'h0000_000, k});
    end
    for (k = 4'h0; k < 4'h5; k++) begin
      d = (k < 4'h4) ? 32'h0000_0100 + {28'h0000_000, k} : dmu_pkg::EMPTY_QUEUE;
      host_rd(dmu_pkg::IDX_IN_QPORT, d);
    end
    host_wr(dmu_pkg::IDX_IN_QPORT, 32'h0000_0200);
    pins(1'h1, 1'h1);
    core_rd(dmu_pkg::IDX_IN_STAT, 32'h0000_0004);
    core_rd(dmu_pkg::IDX_IN_QPORT, 32'h0000_0200);
    pins(1'h0, 1'h1);
    host_wr(dmu_pkg::IDX_OUT_QPORT, 32'h0000_0300);
    core_rd(dmu_pkg::IDX_OUT_QPORT, 32'h0000_0300);
    core_wr(dmu_pkg::IDX_OUT_QPORT, 32'h0000_0400);
    pins(1'h0, 1'h0);
    host_rd(dmu_pkg::IDX_OUT_STAT, 32'h0000_0004);
    host_rd(dmu_pkg::IDX_OUT_QPORT, 32'h0000_0400);
    pins(1'h0, 1'h1);
    // Host stalls with two reads in flight: port refuses, words keep order
    dmu_host_model_inst.issue(1'h0, dmu_pkg::IDX_OUT_MSG1, 32'h0000_0000, ok);
    guard(ok);
    dmu_host_model_inst.issue(1'h0, dmu_pkg::IDX_OUT_MSG0, 32'h0000_0000, ok);
    guard(ok);
    repeat (3) @(negedge clock);
    check({31'h0, pci_ready}, 32'h0000_0000);
    dmu_host_model_inst.collect(d, ok);
    guard(ok);
    check(d, ~32'hC0DE_0001);
    dmu_host_model_inst.collect(d, ok);
    guard(ok);
    check(d, ~32'hC0DE_0000);
    host_rd(4'hF, 32'h0000_0000);
    finish_test();
  end
endmodule
`default_nettype wire
